// ===== rcfs_pkg.sv
// Constants and carriers for the receive client frame status block
package rcfs_pkg;

  // ==========================================================
  // Frame geometry and field positions
  localparam int unsigned BUS_BYTES      = 64;
  localparam logic [15:0] WORD_BYTES     = 16'h0040;
  localparam logic [15:0] MIN_FRAME      = 16'h0040;
  localparam logic [15:0] TINY_MAX       = 16'h0008;
  localparam logic [15:0] LEN_TYPE_LIMIT = 16'h0600;
  localparam logic [15:0] HDR_FCS_BYTES  = 16'h0012;
  localparam logic [15:0] MIN_PAYLOAD    = 16'h002e;
  localparam logic [15:0] CTRL_ETYPE     = 16'h8808;
  localparam logic [15:0] OP_PAUSE       = 16'h0001;
  localparam logic [15:0] OP_PFC         = 16'h0101;
  localparam int unsigned LEN_BYTE_POS   = 12;
  localparam int unsigned OP_BYTE_POS    = 14;

  // ==========================================================
  // Fault flag and frame kind bit positions
  localparam int unsigned FLT_MALFORMED = 0;
  localparam int unsigned FLT_CRC       = 1;
  localparam int unsigned FLT_UNDER     = 2;
  localparam int unsigned FLT_OVER      = 3;
  localparam int unsigned FLT_LEN       = 4;
  localparam int unsigned IRQ_GOOD      = 5;
  localparam int unsigned KIND_PAUSE    = 0;
  localparam int unsigned KIND_PFC      = 1;
  localparam int unsigned KIND_OTHER    = 2;

  // ==========================================================
  // Register indices (byte address is index times four)
  localparam logic [13:0] IDX_MAX_LIMIT  = 14'h0506;
  localparam logic [13:0] IDX_LEN_CHECK  = 14'h050a;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h0600;
  localparam logic [13:0] IDX_IRQ_MASK   = 14'h0601;
  localparam logic [31:0] MAX_LIMIT_RST  = 32'h000005ee;
  localparam logic [31:0] LEN_CHECK_RST  = 32'h00000000;
  localparam logic [5:0]  IRQ_MASK_RST   = 6'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [5:0] empty;
    logic       ctrl_err;
    logic       crc_bad;
  } rcfs_word_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } rcfs_wb_req_t;

endpackage

// ===== rcfs_rx_status.sv
// Receive client stream with per-frame fault and FCS reporting
`timescale 1ns/1ps
`default_nettype none

module rcfs_rx_status #(
  parameter logic [31:0] MAX_LIMIT_RESET = rcfs_pkg::MAX_LIMIT_RST
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire rcfs_pkg::rcfs_wb_req_t wb_req_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       irq_o,
  input  wire rcfs_pkg::rcfs_word_t  link_word_i,
  input  wire logic [511:0]          link_data_i,
  output logic [511:0]               rx_data_o,
  output logic                       rx_packet_begin_o,
  output logic                       rx_packet_end_o,
  output logic                       rx_word_qualifier_o,
  output logic [5:0]                 rx_unused_byte_count_o,
  output logic [5:0]                 rx_frame_fault_flags_o,
  output logic                       rx_checksum_qualifier_o,
  output logic                       rx_checksum_bad_o,
  output logic [2:0]                 rx_ctrl_frame_kind_o
);
  import rcfs_pkg::*;

  // ==========================================================
  // Helpers
  // Two bytes counted from the MSB end of the word
  function automatic logic [15:0] field16(
    input logic [511:0] d,
    input int unsigned  pos
  );
    field16 = d[511 - 8 * pos -: 16];
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // ==========================================================
  // State
  logic        in_pkt_r;
  logic [15:0] cnt_r;
  logic        mal_r;
  logic [15:0] len_field_r;
  logic [15:0] opcode_r;
  logic [31:0] max_lim_r;
  logic [31:0] len_en_r;
  logic [5:0]  irq_status_r;
  logic [5:0]  irq_mask_r;
  logic        out_pkt_r;

  // ==========================================================
  // Word acceptance and length count
  wire        take       = link_word_i.valid
                           & (link_word_i.first | in_pkt_r);
  wire        ends       = take & link_word_i.last;
  wire [15:0] word_bytes = link_word_i.last
                           ? WORD_BYTES - {10'h000, link_word_i.empty}
                           : WORD_BYTES;
  wire [15:0] base_len   = link_word_i.first ? 16'h0000 : cnt_r;
  wire [15:0] tot_len    = base_len + word_bytes;

  // Length/type and opcode, live on the first word
  wire [15:0] len_field  = link_word_i.first
                           ? field16(link_data_i, LEN_BYTE_POS)
                           : len_field_r;
  wire [15:0] opcode     = link_word_i.first
                           ? field16(link_data_i, OP_BYTE_POS)
                           : opcode_r;

  // ==========================================================
  // Fault decode for the end word
  // decoding error
  wire        tiny       = tot_len <= TINY_MAX;
  wire        under      = ~tiny & (tot_len < MIN_FRAME);
  wire        over       = {16'h0000, tot_len} > max_lim_r;
  wire [15:0] payload    = (tot_len >= HDR_FCS_BYTES)
                           ? tot_len - HDR_FCS_BYTES : 16'h0000;
  wire        len_match  = (payload == len_field)
                           | ((payload == MIN_PAYLOAD)
                              & (len_field < MIN_PAYLOAD));
  wire        len_bad    = len_en_r[0] & ~tiny
                           & (len_field < LEN_TYPE_LIMIT) & ~len_match;
  wire        mal_acc    = (mal_r & ~link_word_i.first)
                           | link_word_i.ctrl_err;
  wire        malformed  = mal_acc | tiny;
  wire        crc_bad    = ~tiny & (link_word_i.crc_bad | under);
  wire [5:0]  flags_w    = {1'b0, len_bad, over, under, crc_bad,
                            malformed};

  wire        is_ctrl    = len_field == CTRL_ETYPE;
  wire [2:0]  kind_w;
  assign kind_w[KIND_PAUSE] = is_ctrl & (opcode == OP_PAUSE);
  assign kind_w[KIND_PFC]   = is_ctrl & (opcode == OP_PFC);
  assign kind_w[KIND_OTHER] = is_ctrl & (opcode != OP_PAUSE)
                              & (opcode != OP_PFC);

  // ==========================================================
  // Frame tracking
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_pkt_r    <= 1'b0;
      cnt_r       <= 16'h0000;
      mal_r       <= 1'b0;
      len_field_r <= 16'h0000;
      opcode_r    <= 16'h0000;
    end else if (take) begin
      in_pkt_r    <= ~link_word_i.last;
      cnt_r       <= tot_len;
      mal_r       <= mal_acc;
      len_field_r <= len_field;
      opcode_r    <= opcode;
    end
  end

  // ==========================================================
  // Client outputs, one register stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_data_o               <= '0;
      rx_packet_begin_o       <= 1'b0;
      rx_packet_end_o         <= 1'b0;
      rx_word_qualifier_o     <= 1'b0;
      rx_unused_byte_count_o  <= 6'h00;
      rx_frame_fault_flags_o  <= 6'h00;
      rx_checksum_qualifier_o <= 1'b0;
      rx_checksum_bad_o       <= 1'b0;
      rx_ctrl_frame_kind_o    <= 3'h0;
    end else begin
      rx_data_o               <= link_data_i;
      rx_packet_begin_o       <= take & link_word_i.first;
      rx_packet_end_o         <= ends;
      rx_word_qualifier_o     <= take;
      rx_unused_byte_count_o  <= ends ? link_word_i.empty : 6'h00;
      rx_frame_fault_flags_o  <= ends ? flags_w : 6'h00;
      rx_checksum_qualifier_o <= ends;
      rx_checksum_bad_o       <= ends & crc_bad;
      rx_ctrl_frame_kind_o    <= ends ? kind_w : 3'h0;
    end
  end

  // ==========================================================
  // Wishbone slave decode
  logic        ack_r;
  wire         hit      = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
  wire  [13:0] idx      = wb_req_i.adr[15:2];
  wire         sel_max  = idx == IDX_MAX_LIMIT;
  wire         sel_len  = idx == IDX_LEN_CHECK;
  wire         sel_sts  = idx == IDX_IRQ_STATUS;
  wire         sel_msk  = idx == IDX_IRQ_MASK;
  wire         wr       = hit & wb_req_i.we;
  wire         rd_sts   = hit & ~wb_req_i.we & sel_sts;
  wire  [31:0] rd_data  = sel_max ? max_lim_r
                        : sel_len ? len_en_r
                        : sel_sts ? {26'h0000000, irq_status_r}
                        : sel_msk ? {26'h0000000, irq_mask_r}
                        : 32'h00000000;
  wire  [31:0] msk_wide = merge({26'h0000000, irq_mask_r},
                                wb_req_i.dat, wb_req_i.sel);

  // Events set status; a status read clears, a new event wins
  wire  [5:0]  events   = ends ? {~|flags_w, flags_w[4:0]} : 6'h00;
  wire  [5:0]  sts_nxt  = (irq_status_r & ~{6{rd_sts}}) | events;

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_r    <= hit;
      wb_dat_o <= hit ? rd_data : 32'h00000000;
    end
  end
  assign wb_ack_o = ack_r;

  // Register writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      max_lim_r  <= MAX_LIMIT_RESET;
      len_en_r   <= LEN_CHECK_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr) begin
      if (sel_max) begin
        max_lim_r <= merge(max_lim_r, wb_req_i.dat, wb_req_i.sel);
      end
      if (sel_len) begin
        len_en_r <= merge(len_en_r, wb_req_i.dat, wb_req_i.sel);
      end
      if (sel_msk) begin
        irq_mask_r <= msk_wide[5:0];
      end
    end
  end

  // Interrupt status and level output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_r <= 6'h00;
      irq_o        <= 1'b0;
    end else begin
      irq_status_r <= sts_nxt;
      irq_o        <= |(sts_nxt & irq_mask_r);
    end
  end

  // Output-side packet tracker for checking
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_pkt_r <= 1'b0;
    end else if (rx_packet_end_o) begin
      out_pkt_r <= 1'b0;
    end else if (rx_packet_begin_o) begin
      out_pkt_r <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_short_single: assert property (
    take & link_word_i.first & link_word_i.last
    |=> rx_packet_begin_o & rx_packet_end_o)
    else $error("short frame not single cycle");

  a_flags_eop: assert property (
    !rx_packet_end_o |-> rx_frame_fault_flags_o == 6'h00)
    else $error("fault flags outside end cycle");

  a_ctrl_char: assert property (
    ends & link_word_i.ctrl_err
    |=> rx_frame_fault_flags_o[FLT_MALFORMED])
    else $error("control character not flagged");

  a_crc_mirror: assert property (
    rx_frame_fault_flags_o[FLT_CRC] == rx_checksum_bad_o)
    else $error("crc flag and checksum bad differ");

  a_under_crc: assert property (
    rx_frame_fault_flags_o[FLT_UNDER]
    |-> rx_frame_fault_flags_o[FLT_CRC])
    else $error("undersize without crc flag");

  a_tiny_none: assert property (
    ends & link_word_i.first & (link_word_i.empty >= 6'h38)
    |=> !rx_frame_fault_flags_o[FLT_UNDER] && !rx_checksum_bad_o)
    else $error("tiny data reported as runt");

  a_over_limit: assert property (
    rx_frame_fault_flags_o[FLT_OVER]
    |-> {16'h0000, $past(tot_len)} > $past(max_lim_r))
    else $error("oversize flag below limit");

  a_len_gate: assert property (
    rx_frame_fault_flags_o[FLT_LEN] |-> $past(len_en_r[0]))
    else $error("length fault while check disabled");

  a_word_in_pkt: assert property (
    rx_word_qualifier_o |-> rx_packet_begin_o || out_pkt_r)
    else $error("word qualifier outside packet");

  a_bad_needs_q: assert property (
    rx_checksum_bad_o |-> rx_checksum_qualifier_o)
    else $error("checksum bad without qualifier");

  a_runt_fcs: assert property (
    rx_frame_fault_flags_o[FLT_UNDER] |-> rx_checksum_bad_o)
    else $error("runt without checksum bad");

  a_empty_eop: assert property (
    ends |=> rx_unused_byte_count_o == $past(link_word_i.empty))
    else $error("unused byte count wrong");

endmodule

`default_nettype wire

// ===== rcfs_client_model.sv
// Client-side partner that consumes the receive stream and its status
`timescale 1ns/1ps
`default_nettype none

module rcfs_client_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        begin_i,
  input  wire logic        end_i,
  input  wire logic        qual_i,
  input  wire logic [5:0]  unused_i,
  input  wire logic [5:0]  flags_i,
  input  wire logic        chk_qual_i,
  input  wire logic        chk_bad_i,
  input  wire logic [2:0]  kind_i,
  output logic             done_o,
  output logic [15:0]      rec_o,
  output var logic         proto_err_o
);
  logic in_frame_r;

  // ==========================================================
  // Frame record
  // status read only in end cycles
  assign done_o = end_i;
  assign rec_o  = end_i ? {flags_i, kind_i, unused_i, begin_i} : 16'h0000;

  // ==========================================================
  // Stream protocol watch
  // qualifier and checksum rules
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_frame_r  <= 1'b0;
      proto_err_o <= 1'b0;
    end else begin
      if (qual_i && !(begin_i || in_frame_r)) proto_err_o <= 1'b1;
      if (chk_bad_i && !chk_qual_i) proto_err_o <= 1'b1;
      if (end_i && (chk_bad_i !== flags_i[1])) proto_err_o <= 1'b1;
      if (begin_i) in_frame_r <= 1'b1;
      if (end_i) in_frame_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== rcfs_rx_status_bench.sv
// Self-checking bench for the receive client frame status block
`timescale 1ns/1ps
`default_nettype none

module rcfs_rx_status_bench;
  import rcfs_pkg::*;
  logic         clk_i, rst_i, wb_ack_o, irq_o, pb, pe, qual, cq, cb;
  logic         done, perr;
  rcfs_wb_req_t wb;
  rcfs_word_t   lw;
  logic [511:0] ld, ld_q, dout;
  bit           c, e;
  logic [31:0]  wb_dat_o, r, seed;
  logic [5:0]   ub, ff;
  logic [2:0]   kd;
  logic [15:0]  rec;
  logic [15:0]  exq[$];
  int           mismatches, checks_done, n;
  int           lens[9] = '{8, 9, 63, 64, 65, 127, 128, 1518, 1519};
  logic [15:0]  ops[3] = '{OP_PAUSE, OP_PFC, 16'h0002};

  // ==========================================================
  // Design and partner
  rcfs_rx_status rcfs_rx_status_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .link_word_i(lw), .link_data_i(ld), .rx_data_o(dout),
    .rx_packet_begin_o(pb), .rx_packet_end_o(pe), .rx_word_qualifier_o(qual),
    .rx_unused_byte_count_o(ub), .rx_frame_fault_flags_o(ff),
    .rx_checksum_qualifier_o(cq), .rx_checksum_bad_o(cb),
    .rx_ctrl_frame_kind_o(kd));
  rcfs_client_model rcfs_client_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .begin_i(pb), .end_i(pe), .qual_i(qual), .unused_i(ub), .flags_i(ff),
    .chk_qual_i(cq), .chk_bad_i(cb), .kind_i(kd), .done_o(done),
    .rec_o(rec), .proto_err_o(perr));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected {flags, kind, unused, single cycle} of one frame
  function automatic logic [15:0] expect_rec(int len, bit crc, bit ctl,
      logic [15:0] fld, logic [15:0] op, bit chk, int lim);
    logic [5:0] f;
    logic [2:0] k;
    int         pay;
    f = 6'h00;
    k = 3'h0;
    pay = len - 18;
    if (len <= 8) f = 6'h01;
    else begin
      f[0] = ctl;
      f[2] = (len < 64);
      f[1] = crc | f[2];
      f[3] = (len > lim);
      f[4] = chk && fld < 16'h0600 && !(pay == fld || (pay == 46 && fld < 46));
    end
    if (fld == CTRL_ETYPE) begin
      k = (op == OP_PAUSE) ? 3'h1 : (op == OP_PFC) ? 3'h2 : 3'h4;
    end
    return {f, k, 6'((64 - len % 64) % 64), len <= 64};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One classic bus cycle, held until ack is seen
  task automatic wb_io(input logic w, input logic [15:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    check(wb_ack_o, 1, "bus ack");
    q = wb_dat_o;
    wb <= '0;
  endtask

  // One frame on the link side, words back to back
  task automatic send(input int len, input bit crc, input bit ctl,
      input logic [15:0] fld, input logic [15:0] op, input bit chk,
      input int lim);
    logic [511:0] d;
    int           nw;
    nw = (len + 63) / 64;
    exq.push_back(expect_rec(len, crc, ctl, fld, op, chk, lim));
    for (int w = 0; w < nw; w++) begin
      d = {16{rnd()}};
      if (w == 0) d[415:384] = {fld, op};
      @(posedge clk_i);
      ld <= d;
      lw <= '{valid: 1'b1, first: w == 0, last: w == nw - 1,
              empty: (w == nw - 1) ? 6'((64 - len % 64) % 64) : 6'h00,
              ctrl_err: ctl && w == 0, crc_bad: crc && w == nw - 1};
    end
  endtask

  task automatic drain();
    int k;
    k = 0;
    @(posedge clk_i);
    lw <= '0;
    while (exq.size() != 0 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    check(32'(exq.size()), 0, "frames missing");
  endtask

  task end_sim();
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and per-frame comparison
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    #(40 * 20000);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim();
  end

  // Word the design took at this edge
  always @(posedge clk_i) begin
    ld_q <= ld;
  end

  always @(negedge clk_i) begin
    if (!rst_i && done) begin
      if (exq.size() == 0) check(rec, 32'hffff, "extra frame");
      else check(rec, exq.pop_front(), "frame status");
    end
    if (!rst_i) begin
      check(cq, pe, "checksum qualifier");
      if (qual) check(32'(dout !== ld_q), 0, "rx data");
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'he23e;
    rst_i = 1'b1;
    wb = '0;
    lw = '0;
    ld = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_io(1'b0, 16'h1418, 32'h0, r);
    check(r, MAX_LIMIT_RST, "limit reset");
    wb_io(1'b0, 16'h1428, 32'h0, r);
    check(r, LEN_CHECK_RST, "len check reset");
    wb_io(1'b1, 16'h0100, 32'h5a, r);
    wb_io(1'b0, 16'h0100, 32'h0, r);
    check(r, 32'h0, "unmapped read");
    foreach (lens[i]) send(lens[i], 0, 0, 16'h0800, '0, 0, 1518);
    send(40, 1, 0, 16'h0800, 16'h0, 0, 1518);
    send(200, 1, 1, 16'h0800, 16'h0, 0, 1518);
    foreach (ops[i]) send(64, 0, 0, CTRL_ETYPE, ops[i], 0, 1518);
    drain();
    wb_io(1'b1, 16'h1418, 32'd100, r);
    send(100, 0, 0, 16'h0800, 16'h0, 0, 100);
    send(101, 0, 0, 16'h0800, 16'h0, 0, 100);
    drain();
    wb_io(1'b1, 16'h1418, 32'd1518, r);
    send(100, 0, 0, 16'd81, 16'h0, 0, 1518);
    wb_io(1'b1, 16'h1428, 32'h1, r);
    send(64, 0, 0, 16'd46, 16'h0, 1, 1518);
    send(64, 0, 0, 16'd40, 16'h0, 1, 1518);
    send(64, 0, 0, 16'd50, 16'h0, 1, 1518);
    send(100, 0, 0, 16'd82, 16'h0, 1, 1518);
    send(100, 0, 0, 16'd81, 16'h0, 1, 1518);
    send(100, 0, 0, 16'h0600, 16'h0, 1, 1518);
    drain();
    wb_io(1'b1, 16'h1428, 32'h0, r);
    for (int i = 0; i < 60; i++) begin
      n = 1 + int'(rnd() % 400);
      c = rnd() % 2;
      e = rnd() % 2;
      if (n >= 64 && rnd() % 3 == 0) begin
        send(n, c, e, CTRL_ETYPE, ops[rnd() % 3], 0, 1518);
      end else begin
        send(n, c, e, 16'h0800, 16'h0, 0, 1518);
      end
      if (rnd() % 2) drain();
    end
    drain();
    check(irq_o, 0, "masked irq");
    check(perr, 0, "stream protocol");
    wb_io(1'b0, 16'h1800, 32'h0, r);
    wb_io(1'b1, 16'h1804, 32'h4, r);
    wb_io(1'b0, 16'h1804, 32'h0, r);
    check(r, 32'h4, "mask readback");
    send(40, 0, 0, 16'h0800, 16'h0, 0, 1518);
    drain();
    repeat (2) @(posedge clk_i);
    check(irq_o, 1, "irq raised");
    wb_io(1'b0, 16'h1800, 32'h0, r);
    check(r, 32'h6, "status bits");
    repeat (3) @(posedge clk_i);
    check(irq_o, 0, "irq cleared");
    end_sim();
  end
endmodule
`default_nettype wire
